// file: front_panel_switch_lamp_logic.v
// Purpose: front panel pushbuttons and indicator lamps
// Assumes: button inputs are active low, raw contacts
// Notes:   reset pulse is a fixed length board reset request
`timescale 1ns/1ps
`include "panel_consts.vh"
module button_filter #(
    parameter CNT_W  = 17,
    parameter CYCLES = `DEBOUNCE_CYCLES
) (
    input  wire core_clk,
    input  wire rstn,
    input  wire raw_n,
    output reg  pressed_pulse
);
    reg             sync1;
    reg             sync2;
    reg             stable_n;
    reg [CNT_W-1:0] count;
    reg             next_stable_n;
    reg [CNT_W-1:0] next_count;
    reg             next_pressed;

    // a level must hold unchanged for CYCLES clocks before it is believed
    always @* begin
        next_stable_n = stable_n;
        next_count    = {CNT_W{1'b0}};
        next_pressed  = 1'b0;
        if (sync2 != stable_n) begin
            if (count == CYCLES[CNT_W-1:0] - 1'b1) begin
                next_stable_n = sync2;
                // act on the falling edge of the filtered level only
                next_pressed  = stable_n & ~sync2;
            end else begin
                next_count = count + 1'b1;
            end
        end
    end

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sync1         <= 1'b1;
            sync2         <= 1'b1;
            stable_n      <= 1'b1;
            count         <= {CNT_W{1'b0}};
            pressed_pulse <= 1'b0;
        end else begin
            sync1         <= raw_n;
            sync2         <= sync1;
            stable_n      <= next_stable_n;
            count         <= next_count;
            pressed_pulse <= next_pressed;
        end
    end
endmodule

// one lamp cell: a flop, so the drive never glitches with its source
module lamp_reg (
    input  wire core_clk,
    input  wire rstn,
    input  wire lit,
    output reg  lamp
);
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            lamp <= `LAMP_DARK;
        end else begin
            lamp <= lit;
        end
    end
endmodule

module front_panel_switch_lamp_logic #(
    parameter CNT_W    = 17,
    parameter DEBOUNCE = `DEBOUNCE_CYCLES,
    parameter RST_LEN  = `RESET_PULSE_CYC
) (
    input  wire       core_clk,
    input  wire       rstn,
    input  wire       reset_button_n,
    input  wire       abort_button_n,
    input  wire       reset_button_enable,
    input  wire       abort_enable,
    input  wire [2:0] abort_level,
    input  wire       abort_clear,
    input  wire       is_sys_controller,
    input  wire       board_failure_flag,
    input  wire [2:0] cpu_status,
    input  wire       transfer_in_progress_n,
    input  wire       net_bus_master,
    input  wire       disk_bus_master,
    input  wire       vme_strobe_master,
    input  wire       vme_bus_master,
    output reg        board_reset_n,
    output reg        sysreset_n,
    output reg        sysreset_oe_n,
    output reg  [2:0] abort_irq_level,
    output reg        abort_pending,
    output reg        fail_lamp,
    output reg        status_lamp,
    output reg        run_lamp,
    output reg        sys_controller_lamp,
    output reg        network_master_lamp,
    output reg        disk_master_lamp,
    output reg        backplane_lamp
);
    localparam RST_W = `RST_COUNT_W;

    wire             reset_press;
    wire             abort_press;
    wire             pulse_running;
    wire             reset_accept;
    wire             abort_accept;
    wire             fail_drive;
    wire             status_drive;
    wire             run_drive;
    wire             sys_controller_drive;
    wire             network_drive;
    wire             disk_drive;
    wire             backplane_drive;
    reg  [RST_W-1:0] rst_count;
    reg              rst_to_backplane;
    reg  [RST_W-1:0] next_rst_count;
    reg              next_rst_to_backplane;
    reg              next_pending;
    reg  [2:0]       next_irq_level;

    button_filter #(.CNT_W(CNT_W), .CYCLES(DEBOUNCE)) u_reset_filter (
        .core_clk      (core_clk),
        .rstn          (rstn),
        .raw_n         (reset_button_n),
        .pressed_pulse (reset_press)
    );
    button_filter #(.CNT_W(CNT_W), .CYCLES(DEBOUNCE)) u_abort_filter (
        .core_clk      (core_clk),
        .rstn          (rstn),
        .raw_n         (abort_button_n),
        .pressed_pulse (abort_press)
    );

    assign pulse_running = (rst_count != {RST_W{1'b0}});
    // a press while a pulse is running is dropped, not queued
    assign reset_accept  = reset_press && reset_button_enable && !pulse_running;
    assign abort_accept  = abort_press && abort_enable;

    always @* begin
        next_rst_count        = rst_count;
        next_rst_to_backplane = rst_to_backplane;
        if (reset_accept) begin
            next_rst_count        = RST_LEN[RST_W-1:0];
            // role taken at acceptance; a later change does not cut the pulse
            next_rst_to_backplane = is_sys_controller;
        end else if (pulse_running) begin
            next_rst_count = rst_count - 1'b1;
        end
    end

    // board reset kills this block too, so the pulse counter must survive it:
    // rstn is expected to be the power-on reset, not board_reset_n
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rst_count        <= {RST_W{1'b0}};
            rst_to_backplane <= 1'b0;
            board_reset_n    <= 1'b1;
            sysreset_n       <= 1'b1;
            sysreset_oe_n    <= 1'b1;
        end else begin
            rst_count        <= next_rst_count;
            rst_to_backplane <= next_rst_to_backplane;
            board_reset_n    <= ~pulse_running;
            sysreset_n       <= 1'b0;
            // open drain: only pull low, never drive high
            sysreset_oe_n    <= ~(pulse_running && rst_to_backplane);
        end
    end

    always @* begin
        next_pending = abort_pending;
        // a press in the clearing cycle wins
        if (abort_accept) begin
            next_pending = 1'b1;
        end else if (abort_clear || !abort_enable) begin
            next_pending = 1'b0;
        end
        // level falls with the flag, never a cycle behind it
        next_irq_level = next_pending ? abort_level : `LEVEL_NONE;
    end

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            abort_pending   <= 1'b0;
            abort_irq_level <= `LEVEL_NONE;
        end else begin
            abort_pending   <= next_pending;
            abort_irq_level <= next_irq_level;
        end
    end

    lamp_reg u_fail_lamp (
        .core_clk (core_clk),
        .rstn     (rstn),
        .lit      (board_failure_flag),
        .lamp     (fail_drive)
    );
    lamp_reg u_status_lamp (
        .core_clk (core_clk),
        .rstn     (rstn),
        .lit      (cpu_status == `HALT_CODE),
        .lamp     (status_drive)
    );
    lamp_reg u_run_lamp (
        .core_clk (core_clk),
        .rstn     (rstn),
        .lit      (~transfer_in_progress_n),
        .lamp     (run_drive)
    );
    lamp_reg u_sys_controller_lamp (
        .core_clk (core_clk),
        .rstn     (rstn),
        .lit      (is_sys_controller),
        .lamp     (sys_controller_drive)
    );
    lamp_reg u_network_lamp (
        .core_clk (core_clk),
        .rstn     (rstn),
        .lit      (net_bus_master),
        .lamp     (network_drive)
    );
    lamp_reg u_disk_lamp (
        .core_clk (core_clk),
        .rstn     (rstn),
        .lit      (disk_bus_master),
        .lamp     (disk_drive)
    );
    lamp_reg u_backplane_lamp (
        .core_clk (core_clk),
        .rstn     (rstn),
        .lit      (vme_strobe_master | vme_bus_master),
        .lamp     (backplane_drive)
    );

    // lamp flops live in their cells; the ports only show them
    always @* begin
        fail_lamp           = fail_drive;
        status_lamp         = status_drive;
        run_lamp            = run_drive;
        sys_controller_lamp = sys_controller_drive;
        network_master_lamp = network_drive;
        disk_master_lamp    = disk_drive;
        backplane_lamp      = backplane_drive;
    end
endmodule

// file: panel_consts.vh
// Purpose: constants for the front panel switch and lamp logic
// Assumes: one 10 MHz clock, synchronous inputs apart from the raw button contacts
// Notes:   lamps drive high when lit
// Operation
// - enabled reset button press resets every device on the board
// - reset press also drives backplane system reset when system controller
// - software control disables the reset button completely
// - enabled abort press raises interrupt at software programmed level
// - red failure lamp follows the board failure signal
// - yellow status lamp lights when processor status decodes to halt
// - green run lamp lights while transfer in progress is low
// - system controller lamp lights while acting as system controller
// - network lamp lights while the network controller owns the bus
// - disk lamp lights while the disk controller owns the bus
// - backplane lamp lights on backplane master strobe or incoming access
// - active low edge signals act on their falling edge
`ifndef PANEL_CONSTS_VH
`define PANEL_CONSTS_VH
`define DEBOUNCE_NS     10000000
`define CLK_PERIOD_NS   100
`define DEBOUNCE_CYCLES (`DEBOUNCE_NS / `CLK_PERIOD_NS)
`define RESET_PULSE_CYC 16
`define HALT_CODE       3'h7
`define LEVEL_NONE      3'h0
`define RST_COUNT_W     5
`define LAMP_DARK       1'b0
`endif

// file: panel_checker.sv
// Purpose: port checks for the panel logic
// Assumes: lamps registered one cycle
// Notes:   bound into the top module
`timescale 1ns/1ps
module panel_checker (
    input wire       core_clk,
    input wire       rstn,
    input wire       reset_button_enable,
    input wire       abort_enable,
    input wire [2:0] abort_level,
    input wire       board_failure_flag,
    input wire       transfer_in_progress_n,
    input wire       is_sys_controller,
    input wire       net_bus_master,
    input wire       disk_bus_master,
    input wire       vme_strobe_master,
    input wire       vme_bus_master,
    input wire [2:0] cpu_status,
    input wire       board_reset_n,
    input wire       sysreset_n,
    input wire       sysreset_oe_n,
    input wire [2:0] abort_irq_level,
    input wire       abort_pending,
    input wire       fail_lamp,
    input wire       status_lamp,
    input wire       run_lamp,
    input wire       sys_controller_lamp,
    input wire       network_master_lamp,
    input wire       disk_master_lamp,
    input wire       backplane_lamp
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    property p_fail; 1 |=> fail_lamp == $past(board_failure_flag); endproperty
    a_fail: assert property (p_fail) else $error("fail lamp");
    property p_stat; 1 |=> status_lamp == ($past(cpu_status) == 3'h7); endproperty
    a_stat: assert property (p_stat) else $error("status lamp");
    property p_run; 1 |=> run_lamp == !$past(transfer_in_progress_n); endproperty
    a_run: assert property (p_run) else $error("run lamp");
    property p_sysc; 1 |=> sys_controller_lamp == $past(is_sys_controller); endproperty
    a_sysc: assert property (p_sysc) else $error("controller lamp");
    property p_net; 1 |=> network_master_lamp == $past(net_bus_master); endproperty
    a_net: assert property (p_net) else $error("network lamp");
    property p_disk; 1 |=> disk_master_lamp == $past(disk_bus_master); endproperty
    a_disk: assert property (p_disk) else $error("disk lamp");
    property p_bp; 1 |=> backplane_lamp == $past(vme_strobe_master | vme_bus_master); endproperty
    a_bp: assert property (p_bp) else $error("backplane lamp");
    property p_hold; $fell(board_reset_n) |-> !board_reset_n [*8]; endproperty
    a_hold: assert property (p_hold) else $error("reset too short");
    property p_oe; !sysreset_oe_n |-> !board_reset_n; endproperty
    a_oe: assert property (p_oe) else $error("stray system reset");
    property p_abrt; !abort_enable |=> !abort_pending; endproperty
    a_abrt: assert property (p_abrt) else $error("abort while off");
    property p_lvl;
        1 |=> abort_irq_level == (abort_pending ? $past(abort_level) : 3'h0);
    endproperty
    a_lvl: assert property (p_lvl) else $error("abort level wrong");
    property p_sysn; !sysreset_oe_n |-> !sysreset_n; endproperty
    a_sysn: assert property (p_sysn) else $error("system reset not low");
    property p_ren; $fell(board_reset_n) |-> $past(reset_button_enable, 2); endproperty
    a_ren: assert property (p_ren) else $error("reset while disabled");
endmodule
bind front_panel_switch_lamp_logic panel_checker panel_checker_i (.*);

// file: panel_buttons.sv
// Purpose: front panel contacts
// Assumes: press requests from the bench
// Notes:   contacts close low, no chatter
`timescale 1ns/1ps
module panel_buttons (
    input  wire press_reset,
    input  wire press_abort,
    output wire reset_button_n,
    output wire abort_button_n
);
    // contacts follow the press at once, so they move on the bench's edge
    assign reset_button_n = ~press_reset;
    assign abort_button_n = ~press_abort;
endmodule

// file: tb_front_panel_switch_lamp_logic.sv
// Purpose: bench for the panel logic
// Assumes: short debounce of 4 cycles
// Notes:   presses go through the contact model
`timescale 1ns/1ps
module tb_front_panel_switch_lamp_logic;
    reg core_clk = 0, rstn = 0, pr = 0, pa = 0, ren = 0, aen = 0, aclr = 0, sc = 0;
    reg bf = 0, tip = 1, nm = 0, dm = 0, vs = 0, vm = 0;
    reg [2:0] lvl = 3'h0, st = 3'h0;
    wire rb_n, ab_n, brst_n, sr_n, sr_oe_n, pend, fl, sl, rl, sy, nl, dl, bl;
    wire [2:0] irq;
    integer bad_count = 0, checked = 0, cyc = 0, i, n;
    initial forever #50 core_clk = ~core_clk;
    panel_buttons panel_buttons_i (.press_reset(pr), .press_abort(pa),
        .reset_button_n(rb_n), .abort_button_n(ab_n));
    front_panel_switch_lamp_logic #(.DEBOUNCE(4)) front_panel_switch_lamp_logic_i (
        .core_clk(core_clk), .rstn(rstn), .reset_button_n(rb_n), .abort_button_n(ab_n),
        .reset_button_enable(ren), .abort_enable(aen), .abort_level(lvl), .abort_clear(aclr),
        .is_sys_controller(sc), .board_failure_flag(bf), .cpu_status(st),
        .transfer_in_progress_n(tip), .net_bus_master(nm), .disk_bus_master(dm),
        .vme_strobe_master(vs), .vme_bus_master(vm), .board_reset_n(brst_n), .sysreset_n(sr_n),
        .sysreset_oe_n(sr_oe_n), .abort_irq_level(irq), .abort_pending(pend), .fail_lamp(fl),
        .status_lamp(sl), .run_lamp(rl), .sys_controller_lamp(sy), .network_master_lamp(nl),
        .disk_master_lamp(dl), .backplane_lamp(bl));
    task give_verdict; begin
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    end endtask
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc == 2000) begin bad_count = bad_count + 1; give_verdict; end
    end
    task chk(input [5:0] got, input [5:0] exp); begin
        checked = checked + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    end endtask
    // n returns how many cycles board reset stayed low
    task press(input r); begin
        if (r) pr = 1; else pa = 1;
        n = 0;
        while (brst_n === 1'b1 && pend !== 1'b1 && n < 20) begin @(negedge core_clk); n = n + 1; end
        if (brst_n === 1'b0) chk({sr_n, sr_oe_n}, {1'b0, !sc});
        pr = 0; pa = 0; n = 0;
        while (brst_n === 1'b0 && n < 40) begin @(negedge core_clk); n = n + 1; end
        repeat (12) @(negedge core_clk);
    end endtask
    initial begin
        repeat (3) @(negedge core_clk);
        rstn = 1;
        ren = 1; sc = 1; press(1); chk(n, 16);
        sc = 0; press(1); chk(n, 16);
        pr = 1; repeat (2) @(negedge core_clk); pr = 0; n = 0;
        repeat (16) begin @(negedge core_clk); if (brst_n !== 1'b1) n = n + 1; end
        chk(n, 0);
        ren = 0; press(1); chk(n, 0);
        $display("reset button test done");
        aen = 1; lvl = 3'h5; press(0); chk({pend, irq}, 6'hD);
        aclr = 1; @(negedge core_clk); aclr = 0; chk({pend, irq}, 6'h00);
        aen = 0; press(0); chk({pend, irq}, 6'h00);
        $display("abort button test done");
        for (i = 0; i < 16; i = i + 1) begin
            {vm, sc, tip, bf} = i[3:0]; st = i[2:0]; nm = i[3]; dm = ~i[3]; vs = i[1] & i[2];
            repeat (2) @(negedge core_clk);
            chk({fl, sl, rl}, {bf, st == 3'h7, !tip});
            chk({sy, nl, dl, bl}, {sc, nm, dm, vs | vm});
        end
        $display("lamp test done");
        give_verdict;
    end
endmodule
